// ### iwc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef IWC_MAP_SVH
`define IWC_MAP_SVH
// ==========================================
// register byte offsets
`define IWC_LINE_EN_OFS 8'h00
`define IWC_REQ_FLAG_OFS 8'h04
`define IWC_EDGE_SEL_OFS 8'h08
`define IWC_STACK_PTR_OFS 8'h0c
`define IWC_MISC_OFS 8'h10
`define IWC_CMP_CTRL_OFS 8'h14
`define IWC_CMP_SEL_OFS 8'h18
`define IWC_PORT_DIR_OFS 8'h1c
`define IWC_DIG_IN_EN_OFS 8'h20
`define IWC_TMR_SRC_OFS 8'h24
`define IWC_OSC_EN_OFS 8'h28
`define IWC_STATUS_OFS 8'h2c
// ==========================================
// field positions
`define IWC_MISC_FAST_BIT 5
`define IWC_CMP_EN_BIT 7
`define IWC_CMP_WAKE_BIT 6
`define IWC_OSC_HI 0
`define IWC_OSC_LO 1
`define IWC_OSC_EXT 2
// ==========================================
// widths and sizes
`define IWC_LINES 8
`define IWC_TIMERS 6
`define IWC_SYNC_W 17
// ==========================================
// reset values and constants
`define IWC_OSC_RST 3'h3
`define IWC_STACK_RST 8'h00
`define IWC_VECTOR 16'h0010
`define IWC_SP_STEP 8'h02
`define IWC_SRC_SYS 2'h0
// ==========================================
// wake-up delay in low-speed oscillator periods
`define IWC_WAKE_NORMAL 12'd3000
`define IWC_WAKE_FAST 12'd45
`endif

// ### iwc_pkg.sv
// types shared by the interrupt and wake-up controller
`include "iwc_map.svh"
package iwc_pkg;
    // ==========================================
    // power modes
    typedef enum logic [1:0] {
        IWC_ON,
        IWC_SAVE,
        IWC_DOWN,
        IWC_WAKE
    } iwc_mode_t;

    // ==========================================
    // synchroniser state
    typedef struct packed {
        logic [`IWC_SYNC_W-1:0] s1;
        logic [`IWC_SYNC_W-1:0] s2;
        logic [`IWC_SYNC_W-1:0] s3;
        logic [`IWC_SYNC_W-1:0] q;
    } iwc_sync_t;

    // ==========================================
    // controller state
    typedef struct packed {
        iwc_mode_t mode;
        logic gie;
        logic [7:0] line_en;
        logic [7:0] req_flag;
        logic [15:0] edge_sel;
        logic [7:0] stack_pointer_reg;
        logic [7:0] misc;
        logic [7:0] comparator_control_reg;
        logic [7:0] comparator_select_reg;
        logic [7:0] port_direction_bits;
        logic [7:0] dig_in_en;
        logic [11:0] tmr_src;
        logic [2:0] osc_cfg;
        logic [11:0] wake_cnt;
        logic low_speed_rc_osc_q;
        logic [7:0] src_q;
        logic [7:0] pin_q;
        logic ret_pend;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic stack_we;
        logic stack_re;
        logic [7:0] stack_addr;
        logic [15:0] stack_wdata;
        logic pc_load;
        logic [15:0] pc_value;
        logic cpu_halt;
        logic sysclk_en;
        logic [2:0] osc_en;
        logic progmem_on;
        logic [5:0] timer_run;
        logic resume;
    } iwc_state_t;
endpackage

// ### iwc_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
`include "iwc_map.svh"
module iwc_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // raw and filtered levels
    input wire logic [`IWC_SYNC_W-1:0] d,
    output logic [`IWC_SYNC_W-1:0] q
);
    import iwc_pkg::*;

    iwc_sync_t r;
    iwc_sync_t next_r;

    // ==========================================
    // filter
    // stage one is read only by stage two; metastability stays there
    always_comb begin
        next_r = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.q = (r.s2 & r.s3) | (r.q & (r.s2 ^ r.s3));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.q;
endmodule
`default_nettype wire

// ### iwc_ctrl.sv
// interrupt controller with power-save, power-down and wake-up control
//
// Summary of operation
// - eight request lines, each with its own enable bit
// - hardware sets flags; software clears by writing the flag register
// - flag set on rising, falling or both edges per edge-select field
// - global enable gates all lines; set and clear instructions
// - flags still set when the line enable is zero
// - entry: push pc at sp, sp plus 2, clear global enable, fetch 0x010
// - return: pop pc from stack, sp minus 2, set global enable
// - build option picks one of four pins per external line
// - power-save stops system clock, cpu and program memory; oscillators unchanged
// - power-down stops all oscillators and program memory; state kept
// - in power-save timers on system clock or dead oscillator stop
// - pin toggle wakes power-save when direction and input enable set
// - power-save only: timer on a live non-system clock wakes at match
// - power-save only: comparator wakes when enable and wake bits set
// - power-down wakes only on toggle of input-enabled pin
// - resume after 3000 or 45 low-speed oscillator periods
// - fast boot option forces fast wake; else misc bit 5 selects
// - pin wake resumes after the power instruction, no reset
`timescale 1ns/100ps
`default_nettype none
`include "iwc_map.svh"
module iwc_ctrl (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // build options
    input wire logic [1:0] ext0_sel,
    input wire logic [1:0] ext1_sel,
    input wire logic fast_boot_opt,
    // request sources
    input wire logic [3:0] ext0_pins,
    input wire logic [3:0] ext1_pins,
    input wire logic [5:0] periph_irq,
    // wake sources
    input wire logic [7:0] wake_pins,
    input wire logic [5:0] timer_match,
    input wire logic cmp_event,
    input wire logic low_speed_rc_osc,
    // cpu instruction strobes
    input wire logic engint_req,
    input wire logic disgint_req,
    input wire logic reti_req,
    input wire logic stopexe_req,
    input wire logic stopsys_req,
    input wire logic [15:0] pc_in,
    // stack memory
    output logic stack_we,
    output logic stack_re,
    output logic [7:0] stack_addr,
    output logic [15:0] stack_wdata,
    input wire logic [15:0] stack_rdata,
    // cpu control
    output logic pc_load,
    output logic [15:0] pc_value,
    output logic cpu_halt,
    output logic resume,
    // clock and power control
    output logic sysclk_en,
    output logic [2:0] osc_en,
    output logic progmem_on,
    output logic [5:0] timer_run
);
    import iwc_pkg::*;

    iwc_state_t r;
    iwc_state_t next_r;
    logic [`IWC_SYNC_W-1:0] sync_in;
    logic [`IWC_SYNC_W-1:0] sync_out;
    logic [7:0] src_lvl;
    logic [7:0] edge_hit;
    logic [5:0] tmr_alive;
    logic [7:0] pin_lvl;
    logic low_speed_rc_osc_lvl;

    // ==========================================
    // pin synchronisers
    assign sync_in = {low_speed_rc_osc, wake_pins, ext1_pins, ext0_pins};

    iwc_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(sync_in),
        .q(sync_out)
    );

    assign pin_lvl = sync_out[15:8];
    assign low_speed_rc_osc_lvl = sync_out[16];

    assign src_lvl = {periph_irq, sync_out[4 + ext1_sel], sync_out[ext0_sel]};

    // ==========================================
    // per-line edge detection and timer clock health
    genvar gi;
    generate
        for (gi = 0; gi < `IWC_LINES; gi++) begin : g_line
            logic rise;
            logic fall;
            assign rise = src_lvl[gi] & ~r.src_q[gi];
            assign fall = ~src_lvl[gi] & r.src_q[gi];
            always_comb begin
                case (r.edge_sel[2*gi +: 2])
                    2'h0: edge_hit[gi] = rise;
                    2'h1: edge_hit[gi] = fall;
                    default: edge_hit[gi] = rise | fall;
                endcase
            end
        end
        for (gi = 0; gi < `IWC_TIMERS; gi++) begin : g_tmr
            logic [1:0] src;
            assign src = r.tmr_src[2*gi +: 2];
            // timer needs live non-system clock
            // system source short-circuits the enable index
            assign tmr_alive[gi] = (src != `IWC_SRC_SYS) && r.osc_cfg[src - 2'h1];
        end
    endgenerate

    // ==========================================
    // next state
    logic [7:0] pin_toggle;
    logic wake_save;
    logic wake_down;
    logic fast;
    logic low_speed_rc_osc_rise;
    logic pending;
    logic apb_go;
    logic [11:0] wake_target;

    always_comb begin
        next_r = r;
        pin_toggle = pin_lvl ^ r.pin_q;
        low_speed_rc_osc_rise = low_speed_rc_osc_lvl & ~r.low_speed_rc_osc_q;
        fast = fast_boot_opt | r.misc[`IWC_MISC_FAST_BIT];
        wake_target = fast ? `IWC_WAKE_FAST : `IWC_WAKE_NORMAL;
        wake_save = |(pin_toggle & r.port_direction_bits & r.dig_in_en);
        // timer wake only off system clock
        wake_save = wake_save | |(timer_match & tmr_alive);
        wake_save = wake_save | (cmp_event & r.comparator_control_reg[`IWC_CMP_EN_BIT]
            & r.comparator_select_reg[`IWC_CMP_WAKE_BIT]);
        // power-down wakes on input-enabled pin only
        wake_down = |(pin_toggle & r.dig_in_en);
        // enabled pending line and global enable
        pending = r.gie && |(r.req_flag & r.line_en);
        apb_go = psel & penable;

        next_r.src_q = src_lvl;
        next_r.pin_q = pin_lvl;
        next_r.low_speed_rc_osc_q = low_speed_rc_osc_lvl;
        next_r.stack_we = 1'b0;
        next_r.stack_re = 1'b0;
        next_r.pc_load = 1'b0;
        next_r.resume = 1'b0;
        next_r.ret_pend = 1'b0;

        // ==========================================
        // register bus, one wait state; write lands with pready
        // read data latched on the first access cycle of reads and writes, held until the next access
        next_r.pready = apb_go & ~r.pready;
        if (apb_go && !r.pready) begin
            next_r.pslverr = 1'b0;
            next_r.prdata = 32'h0;
            case (paddr)
                `IWC_LINE_EN_OFS: next_r.prdata[7:0] = r.line_en;
                `IWC_REQ_FLAG_OFS: next_r.prdata[7:0] = r.req_flag;
                `IWC_EDGE_SEL_OFS: next_r.prdata[15:0] = r.edge_sel;
                `IWC_STACK_PTR_OFS: next_r.prdata[7:0] = r.stack_pointer_reg;
                `IWC_MISC_OFS: next_r.prdata[7:0] = r.misc;
                `IWC_CMP_CTRL_OFS: next_r.prdata[7:0] = r.comparator_control_reg;
                `IWC_CMP_SEL_OFS: next_r.prdata[7:0] = r.comparator_select_reg;
                `IWC_PORT_DIR_OFS: next_r.prdata[7:0] = r.port_direction_bits;
                `IWC_DIG_IN_EN_OFS: next_r.prdata[7:0] = r.dig_in_en;
                `IWC_TMR_SRC_OFS: next_r.prdata[11:0] = r.tmr_src;
                `IWC_OSC_EN_OFS: next_r.prdata[2:0] = r.osc_cfg;
                `IWC_STATUS_OFS: next_r.prdata[14:0] = {r.mode, r.gie, r.wake_cnt};
                default: next_r.pslverr = 1'b1;
            endcase
        end else if (!apb_go) begin
            next_r.pslverr = 1'b0;
        end
        if (apb_go && r.pready && pwrite) begin
            case (paddr)
                `IWC_LINE_EN_OFS: next_r.line_en = pwdata[7:0];
                `IWC_REQ_FLAG_OFS: next_r.req_flag = r.req_flag & pwdata[7:0];
                `IWC_EDGE_SEL_OFS: next_r.edge_sel = pwdata[15:0];
                `IWC_STACK_PTR_OFS: next_r.stack_pointer_reg = pwdata[7:0];
                `IWC_MISC_OFS: next_r.misc = pwdata[7:0];
                `IWC_CMP_CTRL_OFS: next_r.comparator_control_reg = pwdata[7:0];
                `IWC_CMP_SEL_OFS: next_r.comparator_select_reg = pwdata[7:0];
                `IWC_PORT_DIR_OFS: next_r.port_direction_bits = pwdata[7:0];
                `IWC_DIG_IN_EN_OFS: next_r.dig_in_en = pwdata[7:0];
                `IWC_TMR_SRC_OFS: next_r.tmr_src = pwdata[11:0];
                `IWC_OSC_EN_OFS: next_r.osc_cfg = pwdata[2:0];
                default: ;
            endcase
        end
        // flags set regardless of line enable; set beats clear
        next_r.req_flag = next_r.req_flag | edge_hit;

        // ==========================================
        // mode sequencing
        case (r.mode)
            IWC_ON: begin
                // a pop in flight outranks every new strobe
                if (r.ret_pend) begin
                    // pc back from stack, resume stream
                    next_r.pc_load = 1'b1;
                    next_r.pc_value = stack_rdata;
                end else if (stopexe_req) begin
                    next_r.mode = IWC_SAVE;
                end else if (stopsys_req) begin
                    next_r.mode = IWC_DOWN;
                end else if (reti_req) begin
                    // pop, sp minus 2, global enable on
                    next_r.stack_pointer_reg = r.stack_pointer_reg - `IWC_SP_STEP;
                    next_r.stack_addr = r.stack_pointer_reg - `IWC_SP_STEP;
                    next_r.stack_re = 1'b1;
                    next_r.ret_pend = 1'b1;
                    next_r.gie = 1'b1;
                end else if (pending) begin
                    // push pc, sp plus 2, mask, vector
                    next_r.stack_we = 1'b1;
                    next_r.stack_addr = r.stack_pointer_reg;
                    next_r.stack_wdata = pc_in;
                    next_r.stack_pointer_reg = r.stack_pointer_reg + `IWC_SP_STEP;
                    next_r.gie = 1'b0;
                    next_r.pc_load = 1'b1;
                    next_r.pc_value = `IWC_VECTOR;
                end else if (engint_req) begin
                    next_r.gie = 1'b1;
                end else if (disgint_req) begin
                    next_r.gie = 1'b0;
                end
            end
            IWC_SAVE: begin
                next_r.wake_cnt = 12'h0;
                if (wake_save) begin
                    next_r.mode = IWC_WAKE;
                end
            end
            IWC_DOWN: begin
                next_r.wake_cnt = 12'h0;
                if (wake_down) begin
                    next_r.mode = IWC_WAKE;
                end
            end
            IWC_WAKE: begin
                if (low_speed_rc_osc_rise) begin
                    next_r.wake_cnt = r.wake_cnt + 12'h1;
                end
                // further wake events are ignored while counting
                if (r.wake_cnt >= wake_target) begin
                    // continue after power instruction, no reset
                    next_r.mode = IWC_ON;
                    next_r.resume = 1'b1;
                    next_r.wake_cnt = 12'h0;
                end
            end
            default: next_r.mode = IWC_ON;
        endcase

        // ==========================================
        // clock and power outputs
        // power-save halts cpu, system clock and program memory
        next_r.cpu_halt = next_r.mode != IWC_ON;
        next_r.sysclk_en = next_r.mode == IWC_ON;
        // power-down stops oscillators and program memory
        // low-speed oscillator forced on with the configured ones while waking so the wake count can run
        case (next_r.mode)
            IWC_DOWN: next_r.osc_en = 3'h0;
            IWC_WAKE: next_r.osc_en = r.osc_cfg | 3'h2;
            default: next_r.osc_en = r.osc_cfg;
        endcase
        next_r.progmem_on = next_r.mode == IWC_ON;
        // timers run on live non-system clocks in power-save
        case (next_r.mode)
            IWC_ON: next_r.timer_run = 6'h3f;
            IWC_SAVE: next_r.timer_run = tmr_alive;
            default: next_r.timer_run = 6'h0;
        endcase
    end

    // ==========================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.mode <= IWC_ON;
            r.osc_cfg <= `IWC_OSC_RST;
            r.osc_en <= `IWC_OSC_RST;
            r.stack_pointer_reg <= `IWC_STACK_RST;
            r.sysclk_en <= 1'b1;
            r.progmem_on <= 1'b1;
            r.timer_run <= 6'h3f;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================
    // outputs, all from flops
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign stack_we = r.stack_we;
    assign stack_re = r.stack_re;
    assign stack_addr = r.stack_addr;
    assign stack_wdata = r.stack_wdata;
    assign pc_load = r.pc_load;
    assign pc_value = r.pc_value;
    assign cpu_halt = r.cpu_halt;
    assign resume = r.resume;
    assign sysclk_en = r.sysclk_en;
    assign osc_en = r.osc_en;
    assign progmem_on = r.progmem_on;
    assign timer_run = r.timer_run;
endmodule
`default_nettype wire

// ### iwc_stack_model.sv
// stack memory model standing for data memory behind the cpu
`timescale 1ns/100ps
`default_nettype none
module iwc_stack_model (
    // clock
    input wire logic pclk,
    // stack port
    input wire logic stack_we,
    input wire logic stack_re,
    input wire logic [7:0] stack_addr,
    input wire logic [15:0] stack_wdata,
    output logic [15:0] stack_rdata
);
    logic [15:0] mem [0:127];
    always @(posedge pclk) begin
        if (stack_we) begin
            mem[stack_addr[7:1]] <= stack_wdata;
        end
    end
    // read data valid only while the read strobe stands, scrambled otherwise
    assign stack_rdata = stack_re ? mem[stack_addr[7:1]] : ~mem[stack_addr[7:1]];
endmodule
`default_nettype wire

// ### iwc_ctrl_chk.sv
// port assertions for the interrupt and wake-up controller
`timescale 1ns/100ps
`default_nettype none
module iwc_ctrl_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // cpu side
    input wire logic stopexe_req,
    input wire logic stopsys_req,
    input wire logic [15:0] pc_in,
    input wire logic stack_we,
    input wire logic stack_re,
    input wire logic [15:0] stack_wdata,
    input wire logic pc_load,
    input wire logic [15:0] pc_value,
    input wire logic cpu_halt,
    input wire logic resume,
    // power
    input wire logic sysclk_en,
    input wire logic [2:0] osc_en,
    input wire logic progmem_on,
    input wire logic [5:0] timer_run
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ====================
    // sequences
    sequence apb_req_s;
        psel && !penable ##1 psel && penable && !pready;
    endsequence
    sequence save_in_s;
        stopexe_req ##1 $rose(cpu_halt);
    endsequence
    sequence down_in_s;
        stopsys_req ##1 $rose(cpu_halt);
    endsequence
    // ====================
    // assertions
    apb_answer_a: assert property (apb_req_s |=> pready)
        else $error("apb answer not one cycle after access");
    unmapped_err_a: assert property (pready && psel && paddr > 8'h2c |-> pslverr)
        else $error("unmapped access without error");
    entry_vector_a: assert property (stack_we |-> pc_load && pc_value == 16'h0010)
        else $error("entry not to vector");
    entry_push_a: assert property (stack_we |-> stack_wdata == $past(pc_in))
        else $error("pushed pc wrong");
    return_load_a: assert property (stack_re |=> pc_load && !stack_we)
        else $error("return load missing");
    halt_cause_a: assert property ($rose(cpu_halt) |-> $past(stopexe_req || stopsys_req))
        else $error("halt without power instruction");
    save_clocks_a: assert property (save_in_s |-> !sysclk_en && osc_en == $past(osc_en))
        else $error("save mode clocks wrong");
    down_clocks_a: assert property (down_in_s |-> osc_en == 3'h0 && !progmem_on && timer_run == 6'h00)
        else $error("down mode clocks wrong");
    halted_quiet_a: assert property (cpu_halt |-> !stack_we && !pc_load)
        else $error("entry while halted");
    resume_cont_a: assert property (resume |-> $past(cpu_halt) && !cpu_halt && sysclk_en && !pc_load)
        else $error("resume not a continuation");
    wake_seen_c: cover property (resume);
endmodule
bind iwc_ctrl iwc_ctrl_chk chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
    .stopexe_req, .stopsys_req, .pc_in, .stack_we, .stack_re, .stack_wdata, .pc_load,
    .pc_value, .cpu_halt, .resume, .sysclk_en, .osc_en, .progmem_on, .timer_run);
`default_nettype wire

// ### iwc_ctrl_test.sv
// self-checking bench for the interrupt and wake-up controller
`timescale 1ns/100ps
`default_nettype none
`include "iwc_map.svh"
module iwc_ctrl_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, stack_we, stack_re, pc_load, cpu_halt, resume;
    logic [1:0] ext0_sel = 2'h2, ext1_sel = 2'h0, div = 2'h0;
    logic fast_boot_opt = 1'b0, cmp_event = 1'b0, low_speed_rc_osc = 1'b0;
    logic [3:0] ext0_pins = 4'h0, ext1_pins = 4'h0;
    logic [5:0] periph_irq = 6'h0, timer_match = 6'h0, timer_run;
    logic [7:0] wake_pins = 8'h0, stack_addr;
    logic engint_req = 1'b0, disgint_req = 1'b0, reti_req = 1'b0;
    logic stopexe_req = 1'b0, stopsys_req = 1'b0, sysclk_en, progmem_on;
    logic [15:0] pc_in = 16'h0, stack_wdata, stack_rdata, pc_value;
    logic [2:0] osc_en;
    int n_mismatch = 0, total_checks = 0;

    iwc_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext0_sel, .ext1_sel, .fast_boot_opt, .ext0_pins, .ext1_pins,
        .periph_irq, .wake_pins, .timer_match, .cmp_event, .low_speed_rc_osc, .engint_req,
        .disgint_req, .reti_req, .stopexe_req, .stopsys_req, .pc_in, .stack_we, .stack_re,
        .stack_addr, .stack_wdata, .stack_rdata, .pc_load, .pc_value, .cpu_halt, .resume,
        .sysclk_en, .osc_en, .progmem_on, .timer_run);
    iwc_stack_model mem (.pclk, .stack_we, .stack_re, .stack_addr, .stack_wdata, .stack_rdata);

    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (osc_en[1] === 1'b1) begin
            div <= div + 2'h1;
        end
        low_speed_rc_osc <= div[1];
    end
    // ====================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic hang;
        n_mismatch++;
        $display("wait ran out at %0t", $time);
        results();
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (i >= 16) hang();
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    task automatic strobe(input int k);
        @(posedge pclk);
        case (k)
            0: engint_req <= 1'b1;
            1: reti_req <= 1'b1;
            2: stopexe_req <= 1'b1;
            3: stopsys_req <= 1'b1;
            default: disgint_req <= 1'b1;
        endcase
        @(posedge pclk);
        {engint_req, reti_req, stopexe_req, stopsys_req, disgint_req} <= 5'h0;
    endtask
    task automatic wait_pc;
        int i;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pc_load !== 1'b1 && i < 32);
        if (i >= 32) hang();
    endtask
    // halt, check clocks, raise one wake source and time the resume
    task automatic sleep(input int op, input int src, input int per);
        int i;
        strobe(op);
        @(posedge pclk);
        chk({cpu_halt, sysclk_en}, 2'b10);
        if (op == 3) begin
            chk({osc_en, progmem_on, timer_run}, 10'h0);
            timer_match <= 6'h01;
            cmp_event <= 1'b1;
            repeat (20) @(posedge pclk);
            chk(cpu_halt, 1'b1);
        end else begin
            chk({osc_en, timer_run}, {3'h3, 6'h01});
        end
        case (src)
            0: wake_pins[0] <= ~wake_pins[0];
            1: timer_match <= 6'h01;
            default: cmp_event <= 1'b1;
        endcase
        i = 0;
        do begin
            @(posedge pclk);
            timer_match <= 6'h0;
            cmp_event <= 1'b0;
            i++;
        end while (resume !== 1'b1 && i < 13000);
        if (i >= 13000) hang();
        chk(i >= 4 * per - 12 && i <= 4 * per + 40, 1'b1);
        @(posedge pclk);
        chk({cpu_halt, sysclk_en}, 2'b01);
    endtask
    // ====================
    // main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk({cpu_halt, sysclk_en, progmem_on, osc_en, timer_run}, 12'h6ff);
        rd(`IWC_OSC_EN_OFS, 32'h3);
        rd(`IWC_STATUS_OFS, 32'h0);
        rd(8'h30, 32'h0);
        chk(rerr, 1'b1);
        apb(1'b1, `IWC_LINE_EN_OFS, 32'ha5);
        rd(`IWC_LINE_EN_OFS, 32'ha5);
        apb(1'b1, `IWC_LINE_EN_OFS, 32'h0);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, `IWC_EDGE_SEL_OFS, m << 4);
            periph_irq[0] <= 1'b1;
            rd(`IWC_REQ_FLAG_OFS, (m != 1) ? 32'h4 : 32'h0);
            apb(1'b1, `IWC_REQ_FLAG_OFS, 32'h0);
            periph_irq[0] <= 1'b0;
            rd(`IWC_REQ_FLAG_OFS, (m != 0) ? 32'h4 : 32'h0);
            apb(1'b1, `IWC_REQ_FLAG_OFS, 32'h0);
            rd(`IWC_REQ_FLAG_OFS, 32'h0);
        end
        ext0_pins <= 4'h2;
        ext1_pins <= 4'h1;
        repeat (8) @(posedge pclk);
        rd(`IWC_REQ_FLAG_OFS, 32'h2);
        ext0_pins <= 4'h6;
        repeat (8) @(posedge pclk);
        rd(`IWC_REQ_FLAG_OFS, 32'h3);
        apb(1'b1, `IWC_REQ_FLAG_OFS, 32'h0);
        apb(1'b1, `IWC_STACK_PTR_OFS, 32'h20);
        apb(1'b1, `IWC_LINE_EN_OFS, 32'h4);
        pc_in <= 16'h1234;
        periph_irq[0] <= 1'b1;
        rd(`IWC_STACK_PTR_OFS, 32'h20);
        strobe(0);
        wait_pc();
        chk(pc_value, 16'h0010);
        chk({stack_addr, stack_wdata}, 24'h20_1234);
        rd(`IWC_STACK_PTR_OFS, 32'h22);
        rd(`IWC_STATUS_OFS, 32'h0);
        pc_in <= 16'h5678;
        apb(1'b1, `IWC_REQ_FLAG_OFS, 32'h0);
        strobe(1);
        wait_pc();
        chk(pc_value, 16'h1234);
        rd(`IWC_STACK_PTR_OFS, 32'h20);
        rd(`IWC_STATUS_OFS, 32'h1000);
        periph_irq[1] <= 1'b1;
        rd(`IWC_REQ_FLAG_OFS, 32'h8);
        rd(`IWC_STACK_PTR_OFS, 32'h20);
        strobe(4);
        rd(`IWC_STATUS_OFS, 32'h0);
        apb(1'b1, `IWC_REQ_FLAG_OFS, 32'h0);
        apb(1'b1, `IWC_PORT_DIR_OFS, 32'h1);
        apb(1'b1, `IWC_DIG_IN_EN_OFS, 32'h1);
        apb(1'b1, `IWC_TMR_SRC_OFS, 32'h32);
        apb(1'b1, `IWC_MISC_OFS, 32'h20);
        sleep(2, 0, 45);
        sleep(2, 1, 45);
        apb(1'b1, `IWC_CMP_CTRL_OFS, 32'h80);
        apb(1'b1, `IWC_CMP_SEL_OFS, 32'h40);
        sleep(2, 2, 45);
        apb(1'b1, `IWC_MISC_OFS, 32'h0);
        sleep(3, 0, 3000);
        rd(`IWC_STACK_PTR_OFS, 32'h20);
        fast_boot_opt <= 1'b1;
        sleep(3, 0, 45);
        results();
    end
endmodule
`default_nettype wire
